// *** design/rpq_pkg.sv ***
// Constants and types for the receive-port video qualifier
// What this block does
// - Discard enabled: drop packets while unqualified
// - Zero-stats bit: unqualified ports read zero counts
// - Line-count change drops qualification until threshold
// - Line-size change drops qualification until threshold
// - Hold mode 0: each parity error deasserts
// - Hold mode 1: parity error clears until threshold
// - Watchdog: no frame end in two periods
// - Watchdog ignored when threshold is zero
// - Threshold zero: qualify on receiver lock
// - Threshold nonzero: qualify after that many frames
// - Port-select register picks the port reached
// - Resume forwarding after truncation once threshold met
package rpq_pkg;
  localparam int NPORT = 4;
  localparam int PSEL_W = 2;
  localparam int WD_W = 24;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
  localparam logic [7:0] OFS_QUAL_CTRL = 8'h7D;
  localparam logic [7:0] OFS_LINES_HI = 8'h73;
  localparam logic [7:0] OFS_LINES_LO = 8'h74;
  localparam logic [7:0] OFS_ROWLEN_HI = 8'h75;
  localparam logic [7:0] OFS_ROWLEN_LO = 8'h76;
  // ****************************************
  // Control fields and reset values
  // ****************************************
  localparam int BIT_DISCARD = 7;
  localparam int BIT_ZERO_STATS = 6;
  localparam int BIT_CHK_LINES = 5;
  localparam int BIT_CHK_SIZE = 4;
  localparam int BIT_PAR_HOLD = 3;
  localparam int BIT_WDOG_OFF = 2;
  localparam int BIT_THR_LSB = 0;
  localparam int THR_W = 2;
  localparam logic [7:0] QUAL_CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_SEL_RST = 8'h00;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic lock;
    logic frame_end;
    logic line_end;
    logic parity_err;
    logic [15:0] line_len;
  } rpq_vid_s;
  typedef struct packed {
    logic last;
    logic [31:0] data;
  } rpq_pkt_s;
  localparam int PKT_W = $bits(rpq_pkt_s);
  typedef enum logic [1:0] {
    ST_UNLOCKED = 2'b00,
    ST_COUNTING = 2'b01,
    ST_QUALIFIED = 2'b11
  } rpq_state_e;
endpackage

// *** design/rpq_skid2.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module rpq_skid2 (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire rpq_pkg::rpq_pkt_s i_data,
  input wire logic i_valid,
  output logic o_ready,
  output rpq_pkg::rpq_pkt_s o_data,
  output logic o_valid,
  input wire logic i_ready
);
  import rpq_pkg::*;
  rpq_pkt_s mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge I_CLK_SYS) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

// *** design/rpq_top.sv ***
// Receive-port video qualification, packet gating and register file
`timescale 1ns/1ps
module rpq_top (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  input wire rpq_pkg::rpq_vid_s I_VID [rpq_pkg::NPORT],
  input wire rpq_pkg::rpq_pkt_s I_PKT [rpq_pkg::NPORT],
  input wire logic [rpq_pkg::NPORT-1:0] I_PKT_VALID,
  output logic [rpq_pkg::NPORT-1:0] O_PKT_READY,
  output rpq_pkg::rpq_pkt_s O_PKT [rpq_pkg::NPORT],
  output logic [rpq_pkg::NPORT-1:0] O_PKT_VALID,
  input wire logic [rpq_pkg::NPORT-1:0] I_PKT_READY,
  output logic [rpq_pkg::NPORT-1:0] O_QUALIFIED
);
  import rpq_pkg::*;
  logic [7:0] port_sel;
  logic [PSEL_W-1:0] sel;
  logic [7:0] ctrl_rd [NPORT];
  logic [15:0] lines_rd [NPORT];
  logic [15:0] rowlen_rd [NPORT];

  assign sel = port_sel[PSEL_W-1:0];

  // ****************************************
  // Port select
  // ****************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      port_sel <= PORT_SEL_RST;
    end else if (I_REG_WR && I_REG_ADDR == OFS_PORT_SEL) begin
      port_sel <= I_REG_WDATA;
    end
  end

  // ****************************************
  // Register readback
  // ****************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        OFS_PORT_SEL: O_REG_RDATA <= port_sel;
        OFS_QUAL_CTRL: O_REG_RDATA <= ctrl_rd[sel];
        OFS_LINES_HI: O_REG_RDATA <= lines_rd[sel][15:8];
        OFS_LINES_LO: O_REG_RDATA <= lines_rd[sel][7:0];
        OFS_ROWLEN_HI: O_REG_RDATA <= rowlen_rd[sel][15:8];
        OFS_ROWLEN_LO: O_REG_RDATA <= rowlen_rd[sel][7:0];
        default: O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Per-port logic
  // ****************************************
  genvar p;
  for (p = 0; p < NPORT; p++) begin : g_port
    logic [7:0] ctrl;
    logic [THR_W-1:0] thresh;
    rpq_vid_s ev;
    rpq_state_e st;
    logic [THR_W-1:0] tally;
    logic [15:0] cur_lines;
    logic [15:0] next_lines;
    logic [15:0] last_lines;
    logic [15:0] last_len;
    logic have_lines;
    logic have_len;
    logic frame_par;
    logic frame_size_bad;
    logic lines_change;
    logic size_change;
    logic frame_ok;
    logic [WD_W-1:0] since;
    logic [WD_W-1:0] period;
    logic have_period;
    logic wd_fire;
    logic drop;
    logic qual;
    logic discard;

    assign ev = I_VID[p];
    assign thresh = ctrl[BIT_THR_LSB +: THR_W];
    assign ctrl_rd[p] = ctrl;

    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
        ctrl <= QUAL_CTRL_RST;
      end else if (I_REG_WR && I_REG_ADDR == OFS_QUAL_CTRL && sel == p) begin
        ctrl <= I_REG_WDATA;
      end
    end

    // Frame geometry tracking
    assign next_lines = cur_lines + {15'h0000, ev.line_end};
    assign lines_change = ev.frame_end && have_lines && next_lines != last_lines;
    assign size_change = ev.line_end && have_len && ev.line_len != last_len;

    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !ev.lock) begin
        cur_lines <= 16'h0000;
        last_lines <= 16'h0000;
        last_len <= 16'h0000;
        have_lines <= 1'b0;
        have_len <= 1'b0;
      end else begin
        if (ev.frame_end) begin
          cur_lines <= 16'h0000;
          last_lines <= next_lines;
          have_lines <= 1'b1;
        end else if (ev.line_end) begin
          cur_lines <= next_lines;
        end
        if (ev.line_end) begin
          last_len <= ev.line_len;
          have_len <= 1'b1;
        end
      end
    end

    // Per-frame error memory
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !ev.lock || ev.frame_end) begin
        frame_par <= 1'b0;
        frame_size_bad <= 1'b0;
      end else begin
        if (ev.parity_err) begin
          frame_par <= 1'b1;
        end
        if (size_change) begin
          frame_size_bad <= 1'b1;
        end
      end
    end

    assign frame_ok = ev.frame_end && !frame_par && !ev.parity_err
      && !(ctrl[BIT_CHK_LINES] && lines_change)
      && !(ctrl[BIT_CHK_SIZE] && (size_change || frame_size_bad));

    // Frame-end watchdog over two measured frame periods
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !ev.lock) begin
        since <= '0;
        period <= '0;
        have_period <= 1'b0;
      end else if (ev.frame_end) begin
        since <= '0;
        if (have_lines) begin
          period <= since + 1'b1;
          have_period <= 1'b1;
        end
      end else if (since != '1) begin
        since <= since + 1'b1;
      end
    end

    assign wd_fire = !ctrl[BIT_WDOG_OFF] && have_period
      && {1'b0, since} >= {period, 1'b0}
      && thresh != '0;

    assign drop = (ctrl[BIT_CHK_LINES] && lines_change)
      || (ctrl[BIT_CHK_SIZE] && size_change)
      || (ctrl[BIT_PAR_HOLD] && ev.parity_err)
      || wd_fire;

    // Qualification state
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST || !ev.lock) begin
        st <= ST_UNLOCKED;
        tally <= '0;
      end else begin
        case (st)
          ST_UNLOCKED: begin
            tally <= '0;
            st <= (thresh == '0) ? ST_QUALIFIED : ST_COUNTING;
          end
          ST_COUNTING: begin
            if (drop) begin
              tally <= '0;
            end else if (thresh == '0) begin
              st <= ST_QUALIFIED;
            end else if (frame_ok) begin
              if (tally + 1'b1 >= thresh) begin
                st <= ST_QUALIFIED;
              end else begin
                tally <= tally + 1'b1;
              end
            end
          end
          ST_QUALIFIED: begin
            if (drop) begin
              st <= ST_COUNTING;
              tally <= '0;
            end
          end
          default: begin
            st <= ST_UNLOCKED;
            tally <= '0;
          end
        endcase
      end
    end

    assign qual = st == ST_QUALIFIED
      && !(ev.parity_err && !ctrl[BIT_PAR_HOLD]);
    assign O_QUALIFIED[p] = qual;

    assign lines_rd[p] = (ctrl[BIT_ZERO_STATS] && !qual) ? 16'h0000 : last_lines;
    assign rowlen_rd[p] = (ctrl[BIT_ZERO_STATS] && !qual) ? 16'h0000 : last_len;

    // Packet gating into the output buffer
    assign discard = ctrl[BIT_DISCARD] && !qual;
    logic buf_ready;
    assign O_PKT_READY[p] = discard ? 1'b1 : buf_ready;

    rpq_skid2 u_buf (
      .I_CLK_SYS(I_CLK_SYS),
      .I_RST(I_RST),
      .i_data(I_PKT[p]),
      .i_valid(I_PKT_VALID[p] && !discard),
      .o_ready(buf_ready),
      .o_data(O_PKT[p]),
      .o_valid(O_PKT_VALID[p]),
      .i_ready(I_PKT_READY[p])
    );
  end
endmodule

// *** testbench/rpq_ser_model.sv ***
// Remote serializer model: lock, line and frame events for one port
`timescale 1ns/1ps
module rpq_ser_model (
  input wire logic i_clk,
  input wire logic i_lock,
  input wire logic i_run,
  input wire logic i_perr,
  input wire logic [3:0] i_lines,
  input wire logic [15:0] i_len,
  output rpq_pkg::rpq_vid_s o_vid
);
  import rpq_pkg::*;
  logic ph;
  logic [3:0] ln;
  always_ff @(posedge i_clk) begin
    o_vid <= '0;
    o_vid.lock <= i_lock;
    o_vid.parity_err <= i_lock & i_perr;
    // Stale length inverted between lines
    o_vid.line_len <= ~o_vid.line_len;
    if (!i_lock) begin
      ph <= 1'b0;
      ln <= '0;
    end else if (i_run) begin
      ph <= ~ph;
      if (ph) begin
        o_vid.line_end <= 1'b1;
        o_vid.line_len <= i_len;
        ln <= (ln + 4'd1 >= i_lines) ? 4'd0 : ln + 4'd1;
        // Last line end coincides with frame end
        o_vid.frame_end <= (ln + 4'd1 >= i_lines);
      end
    end
  end
endmodule

// *** testbench/rpq_sva.sv ***
// Port-level assertions for the receive-port video qualifier
`timescale 1ns/1ps
module rpq_sva (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire rpq_pkg::rpq_vid_s I_VID [rpq_pkg::NPORT],
  input wire logic [rpq_pkg::NPORT-1:0] I_PKT_VALID,
  input wire logic [rpq_pkg::NPORT-1:0] O_PKT_READY,
  input wire rpq_pkg::rpq_pkt_s O_PKT [rpq_pkg::NPORT],
  input wire logic [rpq_pkg::NPORT-1:0] O_PKT_VALID,
  input wire logic [rpq_pkg::NPORT-1:0] I_PKT_READY,
  input wire logic [rpq_pkg::NPORT-1:0] O_QUALIFIED
);
  import rpq_pkg::*;
  default clocking dc @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  sequence s_lost;
    I_VID[0].lock ##1 !I_VID[0].lock;
  endsequence
  sequence s_lockup;
    !I_VID[0].lock ##1 I_VID[0].lock;
  endsequence
  property p_lost;
    s_lost |=> !O_QUALIFIED[0];
  endproperty
  a_lost: assert property (p_lost) else $error("qualified after lock loss");
  property p_unlocked;
    !I_VID[0].lock [*2] |-> !O_QUALIFIED[0];
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("qualified while unlocked");
  property p_early;
    s_lockup |-> !O_QUALIFIED[0];
  endproperty
  a_early: assert property (p_early) else $error("qualified on lock edge");
  property p_rise;
    $rose(O_QUALIFIED[0]) |-> $past(I_VID[0].lock);
  endproperty
  a_rise: assert property (p_rise) else $error("qualified without lock");
  property p_par;
    I_VID[0].lock && I_VID[0].parity_err |-> !O_QUALIFIED[0] or ##1 !O_QUALIFIED[0];
  endproperty
  a_par: assert property (p_par) else $error("parity error kept qualified");
  property p_pkt_rise;
    $rose(O_PKT_VALID[0]) |-> $past(I_PKT_VALID[0]) && $past(O_PKT_READY[0]);
  endproperty
  a_pkt_rise: assert property (p_pkt_rise) else $error("word from nowhere");
  property p_pkt_hold;
    O_PKT_VALID[0] && !I_PKT_READY[0] |=> O_PKT_VALID[0] && $stable(O_PKT[0]);
  endproperty
  a_pkt_hold: assert property (p_pkt_hold) else $error("stalled word lost");
  property p_rdy;
    !O_PKT_VALID[0] |-> O_PKT_READY[0];
  endproperty
  a_rdy: assert property (p_rdy) else $error("empty buffer not ready");
  property p_rd;
    !I_REG_RD |=> $stable(O_REG_RDATA);
  endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
endmodule
bind rpq_top rpq_sva rpq_sva_i (.I_CLK_SYS, .I_RST, .I_REG_RD, .O_REG_RDATA, .I_VID,
  .I_PKT_VALID, .O_PKT_READY, .O_PKT, .O_PKT_VALID, .I_PKT_READY, .O_QUALIFIED);

// *** testbench/tb_top.sv ***
// Self-checking bench for the receive-port video qualifier
`timescale 1ns/1ps
module tb_top;
  import rpq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = '0;
  logic [7:0] wdat = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdat;
  rpq_vid_s vid [NPORT];
  rpq_pkt_s pk [NPORT] = '{default: '0};
  rpq_pkt_s op [NPORT];
  logic [NPORT-1:0] pv = '0;
  logic [NPORT-1:0] prdy = '0;
  logic [NPORT-1:0] lock = '0;
  logic [NPORT-1:0] run = '0;
  logic [NPORT-1:0] perr = '0;
  logic [NPORT-1:0] ordy, ov, q;
  logic [3:0] lines = 4'd3;
  logic [15:0] len = 16'h0100;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int fe = 0;
  initial forever #5 clk = ~clk;
  for (genvar g = 0; g < NPORT; g++) begin : gen_src
    rpq_ser_model rpq_ser_model_i (.i_clk(clk), .i_lock(lock[g]), .i_run(run[g]),
      .i_perr(perr[g]), .i_lines(lines), .i_len(len), .o_vid(vid[g]));
  end
  rpq_top rpq_top_i (.I_CLK_SYS(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdat),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat), .I_VID(vid), .I_PKT(pk),
    .I_PKT_VALID(pv), .O_PKT_READY(ordy), .O_PKT(op), .O_PKT_VALID(ov),
    .I_PKT_READY(prdy), .O_QUALIFIED(q));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (vid[0].frame_end) fe <= fe + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(16'(rdat), 16'(e));
  endtask
  task automatic wq(input logic v, input int n);
    int i = 0;
    while (q[0] !== v && i < n) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(16'(q[0]), 16'(v));
  endtask
  // Apply a drop cause, expect the fall, then requalification
  task automatic drop(input logic [7:0] c, input logic [3:0] l, input logic [15:0] n,
      input logic p, input logic r);
    wr_reg(OFS_QUAL_CTRL, c);
    lines <= l;
    len <= n;
    perr[0] <= p;
    run[0] <= r;
    @(posedge clk);
    perr[0] <= 1'b0;
    wq(1'b0, 40);
    if (c[BIT_ZERO_STATS]) rd_reg(OFS_LINES_LO, 8'h00);
    run[0] <= 1'b1;
    wq(1'b1, 80);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_PORT_SEL, PORT_SEL_RST);
    rd_reg(OFS_QUAL_CTRL, QUAL_CTRL_RST);
    wr_reg(OFS_PORT_SEL, 8'h01);
    wr_reg(OFS_QUAL_CTRL, 8'hA5);
    rd_reg(OFS_QUAL_CTRL, 8'hA5);
    wr_reg(OFS_PORT_SEL, 8'h00);
    rd_reg(OFS_QUAL_CTRL, 8'h00);
    rd_reg(8'h80, 8'h00);
    $display("done: registers");
    lock[0] <= 1'b1;
    run[0] <= 1'b1;
    wq(1'b1, 5);
    repeat (30) @(posedge clk);
    run[0] <= 1'b0;
    repeat (60) @(posedge clk);
    #1;
    chk(16'(q[0]), 16'h0001);
    lock[0] <= 1'b0;
    wq(1'b0, 3);
    $display("done: threshold zero");
    wr_reg(OFS_QUAL_CTRL, 8'h06);
    #1;
    fe = 0;
    lock[0] <= 1'b1;
    run[0] <= 1'b1;
    wq(1'b1, 60);
    chk(16'(fe), 16'h0002);
    chk(16'(q[3:1]), 16'h0000);
    rd_reg(OFS_LINES_LO, 8'h03);
    rd_reg(OFS_ROWLEN_HI, 8'h01);
    perr[0] <= 1'b1;
    @(posedge clk);
    perr[0] <= 1'b0;
    #1;
    chk(16'(q[0]), 16'h0000);
    @(posedge clk);
    #1;
    chk(16'(q[0]), 16'h0001);
    $display("done: threshold two");
    drop(8'h26, 4'd4, 16'h0100, 1'b0, 1'b1);
    drop(8'h16, 4'd4, 16'h0200, 1'b0, 1'b1);
    drop(8'h4E, 4'd4, 16'h0200, 1'b1, 1'b1);
    rd_reg(OFS_LINES_LO, 8'h04);
    drop(8'h02, 4'd4, 16'h0200, 1'b0, 1'b0);
    $display("done: drop causes");
    lock[0] <= 1'b0;
    wr_reg(OFS_QUAL_CTRL, 8'h82);
    pk[0] <= {1'b1, 32'h0000_00ff};
    pv[0] <= 1'b1;
    repeat (3) @(posedge clk);
    pv[0] <= 1'b0;
    #1;
    chk(16'(ov[0]), 16'h0000);
    chk(16'(ordy[0]), 16'h0001);
    lock[0] <= 1'b1;
    wq(1'b1, 60);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pk[0] <= {1'(k), 32'(32'h0000_00a0 + k)};
      pv[0] <= 1'b1;
    end
    @(posedge clk);
    pv[0] <= 1'b0;
    prdy[0] <= 1'b1;
    #1;
    chk(16'(ordy[0]), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      chk(op[0].data[15:0], 16'(16'h00a0 + k));
      chk(16'(op[0].last), 16'(k));
      @(posedge clk);
      #1;
    end
    chk(16'(ov[0]), 16'h0000);
    $display("done: packets");
    complete_run();
  end
endmodule
